// ===== src/bqa_bus_arbiter.sv
// external bus arbiter: back-off, hold grant, pending request and qualifiers
// assumes pins synchronous to clk_i; pin tristate is resolved outside
`timescale 1ns/1ps
module bqa_bus_arbiter
  import bqa_pkg::*;
#(
  parameter int ADDR_W = bqa_pkg::BQA_ADDR_W,
  parameter int DATA_W = bqa_pkg::BQA_DATA_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // request side from the internal bus controller
  input wire logic core_req_valid_i,
  output logic core_req_ready_o,
  input wire logic core_write_i,
  input wire logic core_data_not_code_i,
  input wire logic core_dma_i,
  input wire logic core_priv_i,
  input wire logic core_lock_i,
  input wire logic [ADDR_W-1:0] core_addr_i,
  input wire logic [DATA_W-1:0] core_wdata_i,
  output logic core_done_o,
  output logic [DATA_W-1:0] core_rdata_o,
  // external bus
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe_n_o,
  output logic [DATA_W-1:0] data_o,
  input wire logic [DATA_W-1:0] data_i,
  output logic data_oe_n_o,
  output logic addr_strobe_n_o,
  output logic wr_not_rd_o,
  output logic data_not_code_o,
  output logic dma_o,
  output logic priv_access_o,
  output logic lock_n_o,
  output logic ctl_oe_n_o,
  input wire logic ready_n_i,
  input wire logic backoff_in_n_i,
  input wire logic hold_req_i,
  output logic hold_grant_o,
  output logic bus_pending_req_o
);

  bqa_state_t state_reg;
  bqa_state_t state_next;
  logic accept, busy, backoff, hold_carry_reg;
  logic pending_reg, lock_reg, done_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic bus_float;

  bqa_req_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) req_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // request acceptance

  assign backoff = !backoff_in_n_i;
  assign busy = (state_reg == BQA_ST_ADDR) || (state_reg == BQA_ST_DATA);
  // no new access while hold is requested or still carried out of reset
  assign core_req_ready_o = rstn_i && (state_reg == BQA_ST_IDLE) &&
                            !hold_req_i && !hold_carry_reg && !backoff;
  assign accept = core_req_valid_i && core_req_ready_o;

  assign req_bus.load = accept;
  assign req_bus.write = core_write_i;
  assign req_bus.data_not_code = core_data_not_code_i;
  assign req_bus.dma = core_dma_i;
  assign req_bus.priv = core_priv_i;
  assign req_bus.addr = core_addr_i;
  assign req_bus.wdata = core_wdata_i;

  bqa_qual_latch #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_qual (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .req(req_bus),
    .wr_not_rd_o(wr_not_rd_o),
    .data_not_code_o(data_not_code_o),
    .dma_o(dma_o),
    .priv_access_o(priv_access_o),
    .addr_o(addr_o),
    .wdata_o(data_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus sequencer

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      BQA_ST_IDLE:
      begin
        // hold is only taken here, so a running access always ends first
        if (hold_req_i)
          state_next = BQA_ST_HOLD;
        else if (accept)
          state_next = BQA_ST_ADDR;
      end
      BQA_ST_ADDR:
      begin
        if (backoff)
          state_next = BQA_ST_BACKOFF_IN;
        else
          state_next = BQA_ST_DATA;
      end
      BQA_ST_DATA:
      begin
        // backoff wins over a ready seen in the same cycle
        if (backoff)
          state_next = BQA_ST_BACKOFF_IN;
        else if (!ready_n_i)
          state_next = BQA_ST_IDLE;
      end
      BQA_ST_BACKOFF_IN:
      begin
        if (!backoff)
          state_next = BQA_ST_ADDR;
      end
      BQA_ST_HOLD:
      begin
        if (!hold_req_i)
          state_next = BQA_ST_IDLE;
      end
      default:
        state_next = BQA_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_reg <= BQA_ST_IDLE;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold grant, alive through reset

  // unreset flop: follows the request during reset so the grant does not
  // blink off at reset release; needs one clock edge inside reset
  always_ff @(posedge clk_i)
  begin
    hold_carry_reg <= !rstn_i && hold_req_i;
  end

  always_comb
  begin
    if (!rstn_i)
      hold_grant_o = hold_req_i;
    else
      hold_grant_o = (state_reg == BQA_ST_HOLD) || hold_carry_reg;
  end

  // float everything on grant or backoff
  assign bus_float = hold_grant_o || (state_reg == BQA_ST_BACKOFF_IN);
  assign addr_oe_n_o = bus_float;
  assign ctl_oe_n_o = bus_float;
  assign data_oe_n_o = bus_float || !wr_not_rd_o ||
                       (state_reg != BQA_ST_DATA);
  assign addr_strobe_n_o = (state_reg != BQA_ST_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // pending request, lock, completion

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pending_reg <= BQA_PEND_RST;
    else
      pending_reg <= (core_req_valid_i && !accept) ||
                     (state_next == BQA_ST_BACKOFF_IN);
  end
  assign bus_pending_req_o = pending_reg;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      lock_reg <= !BQA_LOCK_N_RST;
    else
      lock_reg <= core_lock_i;
  end
  assign lock_n_o = !lock_reg;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      done_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      done_reg <= (state_reg == BQA_ST_DATA) && !backoff && !ready_n_i;
      if ((state_reg == BQA_ST_DATA) && !backoff && !ready_n_i &&
          !wr_not_rd_o)
        rdata_reg <= data_i;
    end
  end
  assign core_done_o = done_reg;
  assign core_rdata_o = rdata_reg;
  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_accept;
    accept;
  endsequence
  sequence s_resume;
    (state_reg == BQA_ST_BACKOFF_IN) && !backoff;
  endsequence
  property p_backoff_in_float;
    @(posedge clk_i) disable iff (!rstn_i)
    (busy && backoff) |=> addr_oe_n_o && ctl_oe_n_o && data_oe_n_o;
  endproperty
  a_backoff_in_float: assert property (p_backoff_in_float)
    else $error("bus not floated after backoff");
  property p_backoff_in_resume;
    @(posedge clk_i) disable iff (!rstn_i)
    s_resume |=> !addr_strobe_n_o ##1 (state_reg != BQA_ST_ADDR);
  endproperty
  a_backoff_in_resume: assert property (p_backoff_in_resume)
    else $error("strobe not reasserted after backoff");
  property p_hold_float;
    @(posedge clk_i) disable iff (!rstn_i)
    hold_grant_o |-> addr_oe_n_o && data_oe_n_o && ctl_oe_n_o;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("bus driven during hold grant");
  property p_hold_in_reset;
    @(posedge clk_i)
    (!rstn_i && hold_req_i) |-> hold_grant_o;
  endproperty
  a_hold_in_reset: assert property (p_hold_in_reset)
    else $error("hold not granted during reset");
  property p_pending;
    @(posedge clk_i) disable iff (!rstn_i)
    (state_reg == BQA_ST_BACKOFF_IN) |-> bus_pending_req_o;
  endproperty
  a_pending: assert property (p_pending)
    else $error("suspended access not shown as pending");
  property p_qual_dir;
    @(posedge clk_i) disable iff (!rstn_i)
    s_accept |=> (data_not_code_o == $past(core_data_not_code_i)) &&
                 (wr_not_rd_o == $past(core_write_i));
  endproperty
  a_qual_dir: assert property (p_qual_dir)
    else $error("data-or-code out of step with direction");
  property p_qual_src;
    @(posedge clk_i) disable iff (!rstn_i)
    s_accept |=> (dma_o == $past(core_dma_i)) &&
                 (priv_access_o == $past(core_priv_i));
  endproperty
  a_qual_src: assert property (p_qual_src)
    else $error("dma or privilege qualifier wrong");
  property p_finish_first;
    @(posedge clk_i) disable iff (!rstn_i)
    (busy && hold_req_i) |-> !hold_grant_o;
  endproperty
  a_finish_first: assert property (p_finish_first)
    else $error("hold granted during an access");
  property p_strobe_once;
    @(posedge clk_i) disable iff (!rstn_i)
    !addr_strobe_n_o |=> addr_strobe_n_o;
  endproperty
  a_strobe_once: assert property (p_strobe_once)
    else $error("strobe longer than one clock");
  property p_hold_locked;
    @(posedge clk_i) disable iff (!rstn_i)
    ((state_reg == BQA_ST_IDLE) && hold_req_i && lock_reg) |=> hold_grant_o;
  endproperty
  a_hold_locked: assert property (p_hold_locked)
    else $error("hold refused while locked");
  property p_qual_stable;
    @(posedge clk_i) disable iff (!rstn_i)
    (state_reg == BQA_ST_DATA) |->
      $stable(data_not_code_o) && $stable(dma_o) && $stable(priv_access_o);
  endproperty
  a_qual_stable: assert property (p_qual_stable)
    else $error("qualifier changed inside an access");

endmodule

// ===== src/bqa_pkg.sv
// shared constants for the bus arbitration and request qualifier block
// assumes a single 200 MHz bus clock and an active-low asynchronous reset
package bqa_pkg;

  localparam int BQA_ADDR_W = 32;
  localparam int BQA_DATA_W = 32;

  // reset values of the registered pins
  localparam logic BQA_STROBE_N_RST = 1'b1;
  localparam logic BQA_LOCK_N_RST = 1'b1;
  localparam logic BQA_QUAL_RST = 1'b0;
  localparam logic BQA_PEND_RST = 1'b0;

  typedef enum logic [2:0] {
    BQA_ST_IDLE,
    BQA_ST_ADDR,
    BQA_ST_DATA,
    BQA_ST_BACKOFF_IN,
    BQA_ST_HOLD
  } bqa_state_t;

endpackage

// ===== src/bqa_req_if.sv
// carrier for one accepted bus request, from the arbiter to the qualifier latch
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface bqa_req_if #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
);
  logic load;
  logic write;
  logic data_not_code;
  logic dma;
  logic priv;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;

  modport src (
    output load, write, data_not_code, dma, priv, addr, wdata
  );
  modport dst (
    input load, write, data_not_code, dma, priv, addr, wdata
  );
endinterface

// ===== src/bqa_qual_latch.sv
// holds address, write data and per-access qualifiers for one bus access
// assumes load is a one-cycle pulse at the acceptance of a request
`timescale 1ns/1ps
module bqa_qual_latch
  import bqa_pkg::*;
#(
  parameter int ADDR_W = bqa_pkg::BQA_ADDR_W,
  parameter int DATA_W = bqa_pkg::BQA_DATA_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  bqa_req_if.dst req,
  output logic wr_not_rd_o,
  output logic data_not_code_o,
  output logic dma_o,
  output logic priv_access_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o
);

  // direction and data-or-code share one flop edge so they move together
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_not_rd_o <= BQA_QUAL_RST;
      data_not_code_o <= BQA_QUAL_RST;
      dma_o <= BQA_QUAL_RST;
      priv_access_o <= BQA_QUAL_RST;
    end
    else if (req.load)
    begin
      wr_not_rd_o <= req.write;
      data_not_code_o <= req.data_not_code;
      dma_o <= req.dma;
      priv_access_o <= req.priv;
    end
  end

  // held until the next load, so decoders see them for the whole access
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      addr_o <= '0;
      wdata_o <= '0;
    end
    else if (req.load)
    begin
      addr_o <= req.addr;
      wdata_o <= req.wdata;
    end
  end

endmodule

// ===== tb/bqa_far_model.sv
// far-side memory model: answers each strobed access after a set wait
// assumes arbiter pins on the same clock; drives on the falling edge
`timescale 1ns/1ps
module bqa_far_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic addr_strobe_n_i,
  input wire logic [31:0] addr_i,
  input wire logic backoff_n_i,
  input wire logic [3:0] wait_i,
  output logic ready_n_o,
  output logic [31:0] data_o
);
  logic busy_reg;
  logic [3:0] cnt_reg;
  always @(negedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      ready_n_o <= 1'b1;
      data_o <= 32'h0;
    end
    else
    begin
      ready_n_o <= 1'b1;
      // released lines toggle so stale data never looks valid
      data_o <= ~data_o;
      if (!addr_strobe_n_i)
      begin
        busy_reg <= 1'b1;
        cnt_reg <= wait_i;
      end
      // a backed-off access is stalled, not answered while backoff is held
      else if (busy_reg && ready_n_o && backoff_n_i)
      begin
        if (cnt_reg == 4'h0)
        begin
          ready_n_o <= 1'b0;
          data_o <= addr_i ^ 32'h5A5A_A5A5;
        end
        else
          cnt_reg <= cnt_reg - 4'h1;
      end
      else if (!ready_n_o)
        busy_reg <= 1'b0;
    end
  end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the bus arbiter: qualifiers, backoff, hold
// assumes the far model answers reads with address xor a fixed mask
`timescale 1ns/1ps
module testbench;
  import bqa_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i, core_req_valid_i, core_write_i, core_data_not_code_i;
  logic core_dma_i, core_priv_i, core_lock_i, ready_n_i;
  logic backoff_in_n_i, hold_req_i, core_req_ready_o, core_done_o;
  logic addr_oe_n_o, data_oe_n_o, addr_strobe_n_o, wr_not_rd_o;
  logic data_not_code_o, dma_o, priv_access_o, lock_n_o, ctl_oe_n_o;
  logic hold_grant_o, bus_pending_req_o;
  logic [31:0] core_addr_i, core_wdata_i, data_i, core_rdata_o;
  logic [31:0] addr_o, data_o, r;
  logic [31:0] seed = 32'h7C44;
  logic [3:0] wait_c;
  int n_mismatch = 0;
  int n_tests = 0;

  always #2.5 clk_i = ~clk_i;

  bqa_bus_arbiter bqa_bus_arbiter_i (.clk_i, .rstn_i, .core_req_valid_i,
    .core_req_ready_o, .core_write_i, .core_data_not_code_i, .core_dma_i,
    .core_priv_i, .core_lock_i, .core_addr_i, .core_wdata_i, .core_done_o,
    .core_rdata_o, .addr_o, .addr_oe_n_o, .data_o, .data_i, .data_oe_n_o,
    .addr_strobe_n_o, .wr_not_rd_o, .data_not_code_o, .dma_o,
    .priv_access_o, .lock_n_o, .ctl_oe_n_o, .ready_n_i, .backoff_in_n_i,
    .hold_req_i, .hold_grant_o, .bus_pending_req_o);

  bqa_far_model bqa_far_model_i (.clk_i, .rstn_i,
    .addr_strobe_n_i(addr_strobe_n_o), .addr_i(addr_o),
    .backoff_n_i(backoff_in_n_i), .wait_i(wait_c), .ready_n_o(ready_n_i),
    .data_o(data_i));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic timeout();
    n_mismatch++;
    final_report();
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // r[3:0] = write, data, dma, priv; r[5:4] = wait states
  task automatic access(input logic [31:0] q, a, wd, input logic bo);
    int i;
    @(negedge clk_i);
    core_req_valid_i <= 1'b1;
    {core_write_i, core_data_not_code_i, core_dma_i, core_priv_i} <= q[3:0];
    core_addr_i <= a;
    core_wdata_i <= wd;
    wait_c <= bo ? 4'h2 : {2'b00, q[5:4]};
    i = 0;
    #1;
    while (core_req_ready_o !== 1'b1)
    begin
      @(negedge clk_i);
      #1;
      i++;
      if (i > 40)
        timeout();
    end
    @(negedge clk_i);
    core_req_valid_i <= 1'b0;
    chk("strobe", addr_strobe_n_o, 1'b0);
    chk("wnr", wr_not_rd_o, q[3]);
    chk("dnc", data_not_code_o, q[2]);
    chk("dma", dma_o, q[1]);
    chk("priv", priv_access_o, q[0]);
    chk("addr", addr_o, a);
    @(negedge clk_i);
    chk("strobe1", addr_strobe_n_o, 1'b1);
    chk("qual", {wr_not_rd_o, data_not_code_o, dma_o, priv_access_o},
      q[3:0]);
    chk("doe", data_oe_n_o, !q[3]);
    if (q[3])
      chk("wdata", data_o, wd);
    if (bo)
    begin
      backoff_in_n_i <= 1'b0;
      @(negedge clk_i);
      chk("float", {addr_oe_n_o, ctl_oe_n_o, data_oe_n_o, bus_pending_req_o},
        4'hF);
      @(negedge clk_i);
      backoff_in_n_i <= 1'b1;
      @(negedge clk_i);
      chk("resume", {addr_strobe_n_o, data_not_code_o}, {1'b0, q[2]});
    end
    i = 0;
    while (core_done_o !== 1'b1)
    begin
      chk("nogrant", hold_grant_o, 1'b0);
      @(negedge clk_i);
      i++;
      if (i > 30)
        timeout();
    end
    if (!q[3])
      chk("rdata", core_rdata_o, a ^ 32'h5A5A_A5A5);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn_i = 1'b0;
    hold_req_i = 1'b1;
    {core_req_valid_i, core_write_i, core_data_not_code_i} = 3'h0;
    {core_dma_i, core_priv_i, core_lock_i} = 3'h0;
    backoff_in_n_i = 1'b1;
    core_addr_i = 32'h0;
    core_wdata_i = 32'h0;
    wait_c = 4'h0;
    repeat (3) @(negedge clk_i);
    chk("rgrant", {hold_grant_o, addr_oe_n_o}, 2'h3);
    hold_req_i <= 1'b0;
    repeat (9) @(negedge clk_i);
    chk("rgrant0", hold_grant_o, 1'b0);
    rstn_i <= 1'b1;
    // every qualifier code, random waits, some backed off
    for (int k = 0; k < 16; k++)
    begin
      r = (rnd() & 32'hFFFF_FFF0) | k;
      access(r, rnd(), rnd(), r[8] & r[9]);
    end
    access(32'h6, 32'hFFFF_FFFC, 32'h0, 1'b1);
    access(32'hD, 32'h0000_0004, 32'hA5A5_0F0F, 1'b1);
    // hold raised mid-access under lock must wait for completion
    core_lock_i <= 1'b1;
    fork
      access(32'h3C, 32'h1234_5678, 32'h0, 1'b0);
      begin
        repeat (2) @(negedge clk_i);
        hold_req_i <= 1'b1;
      end
    join
    @(negedge clk_i);
    chk("hold", {hold_grant_o, addr_oe_n_o, ctl_oe_n_o, data_oe_n_o},
      4'hF);
    core_req_valid_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk("pend", {core_req_ready_o, bus_pending_req_o, lock_n_o},
      3'h2);
    hold_req_i <= 1'b0;
    access(32'h5, 32'h0000_0100, 32'h0, 1'b0);
    final_report();
  end
endmodule
